//--- src/adcr_clkdiv.sv
/*
 * Divide-by-ratio clock generator for the divided clock output.
 * Assumes the enable comes from a register on the same clock; the output is
 * a flip-flop so it carries no glitch when enabled or disabled.
 */
module adcr_clkdiv
	import adcr_pkg::*;
#(
	parameter int RATIO = DIV_RATIO
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	// Control and output
	input  wire logic en,
	output logic      clk_out
);

	typedef struct packed {
		logic [$clog2(RATIO)-1:0] cnt;
		logic                     out;
	} adcr_div_t;

	adcr_div_t r_reg;
	adcr_div_t r_next;

	always_comb begin
		r_next = r_reg;
		if (ce) begin
			if (!en) begin
				// Parked low so re-enabling always starts a full period
				r_next = '0;
			end else begin
				r_next.cnt = r_reg.cnt + 1'b1;
				r_next.out = r_reg.cnt[$clog2(RATIO)-1];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign clk_out = r_reg.out;

endmodule : adcr_clkdiv

//--- src/adcr_pkg.sv
/*
 * Constants shared by the converter configuration register slice: register
 * indices, slot numbering, reset values, writable-bit masks and field positions.
 * Assumes the APB slave places each 8-bit register in the low byte of one word
 * at byte address four times its index.
 */
package adcr_pkg;

	// Speed grades of the converter
	typedef enum logic [1:0] {
		ADCR_GRADE_SLOW,
		ADCR_GRADE_STD,
		ADCR_GRADE_FAST
	} adcr_grade_t;

	// Register indices (word index; byte address is four times the index)
	localparam logic [9:0] IDX_XFER    = 10'h0ff;
	localparam logic [9:0] IDX_CALCTL  = 10'h10a;
	localparam logic [9:0] IDX_THR     = 10'h10e;
	localparam logic [9:0] IDX_DIVIDED_CLOCK_OUTPUT  = 10'h120;
	localparam logic [9:0] IDX_TRIM    = 10'h121;
	localparam logic [9:0] IDX_RSV     = 10'h12a;
	localparam logic [9:0] IDX_G0      = 10'h130;
	localparam logic [9:0] IDX_N0L     = 10'h131;
	localparam logic [9:0] IDX_N0H     = 10'h132;
	localparam logic [9:0] IDX_G1      = 10'h138;
	localparam logic [9:0] IDX_N1L     = 10'h139;
	localparam logic [9:0] IDX_N1H     = 10'h13a;

	// Storage slots of the shadowed registers
	localparam int NSLOT     = 11;
	localparam logic [3:0] SL_THR    = 4'h0;
	localparam logic [3:0] SL_CALCTL = 4'h1;
	localparam logic [3:0] SL_DIVIDED_CLOCK_OUTPUT = 4'h2;
	localparam logic [3:0] SL_TRIM   = 4'h3;
	localparam logic [3:0] SL_RSV    = 4'h4;
	localparam logic [3:0] SL_G0     = 4'h5;
	localparam logic [3:0] SL_N0L    = 4'h6;
	localparam logic [3:0] SL_N0H    = 4'h7;
	localparam logic [3:0] SL_G1     = 4'h8;
	localparam logic [3:0] SL_N1L    = 4'h9;
	localparam logic [3:0] SL_N1H    = 4'ha;

	// Reset values
	localparam logic [7:0] RST_THR       = 8'h14;
	localparam logic [7:0] RST_CALCTL    = 8'h10;
	localparam logic [7:0] RST_DIVIDED_CLOCK_OUTPUT    = 8'h11;
	localparam logic [7:0] RST_TRIM_SLOW = 8'h03;
	localparam logic [7:0] RST_TRIM_FAST = 8'h00;
	localparam logic [7:0] RST_RSV       = 8'h05;
	localparam logic [7:0] RST_ZERO      = 8'h00;

	// Writable bits; all others ignore writes and read zero
	localparam logic [7:0] MSK_FULL   = 8'hff;
	localparam logic [7:0] MSK_CALCTL = 8'h10;
	localparam logic [7:0] MSK_DIVIDED_CLOCK_OUTPUT = 8'h1b;
	localparam logic [7:0] MSK_LOW2   = 8'h03;
	localparam logic [7:0] MSK_GAIN   = 8'h33;

	// Field positions
	localparam int BIT_XFER      = 0;
	localparam int BIT_CAL_EN    = 4;
	localparam int BIT_DIV_EN    = 4;
	localparam int BIT_DIV_TERM  = 3;
	localparam int POS_SWING     = 0;
	localparam int POS_GAIN_D2   = 4;
	localparam int POS_GAIN_D8   = 0;

	// Divided clock ratio and NCO width
	localparam int DIV_RATIO  = 4;
	localparam int NCO_W      = 10;

endpackage : adcr_pkg

//--- src/adcr_regs.sv
/*
 * Configuration register slice of a sampling converter behind an APB slave:
 * calibration threshold, divided clock output control, sample-rate trim,
 * reserved register, downconverter gains and NCO phase increments, with
 * master/slave shadowing and a small NCO phase accumulator per channel.
 * Assumes pclk stands in for the sample clock and that the APB master holds
 * its request until pready.
 */
// Behaviour
// - Divided clock runs at quarter rate
// - Divided clock control bit 4 enables output
// - Bit 3 selects termination mode
// - Bits 1:0 select output swing
// - Standard grades: trim codes select rate ranges
// - Fastest grade: trim codes select rate ranges
// - Slowest grade: trim resets 3, only 3
// - Faster grades: trim resets to zero
// - Channel 0 bits 5:4 decimate-by-2 gain
// - Channel 0 bits 1:0 decimate-by-8 gain
// - Channel 1 has identical gain register
// - Channel 0 increment: 0x131 low, 0x132 high
// - NCO frequency is increment times rate/1024
// - Threshold register 0x10E resets to 0x14
// - Channel 1 increment: 0x139 low, 0x13A high
// - Transfer bit copies master into slave registers
// - Threshold used only when calibration bit 4 set
module adcr_regs
	import adcr_pkg::*;
#(
	parameter adcr_grade_t GRADE = ADCR_GRADE_STD
) (
	// Clock, reset, clock enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Divided clock output and its pad controls
	output logic             divided_clock_output,
	output logic             divided_clock_output_term_none,
	output logic      [1:0]  divided_clock_output_swing,
	// Converter trim and calibration
	output logic      [1:0]  trim_code,
	output logic      [7:0]  gain_cal_threshold,
	output logic             gain_cal_threshold_en,
	output logic      [7:0]  reserved_cfg,
	// Downconverter channel 0
	output logic      [1:0]  ddc0_gain_d2,
	output logic      [1:0]  ddc0_gain_d8,
	output logic      [9:0]  ddc0_nco_inc,
	output logic      [9:0]  ddc0_nco_phase,
	// Downconverter channel 1
	output logic      [1:0]  ddc1_gain_d2,
	output logic      [1:0]  ddc1_gain_d8,
	output logic      [9:0]  ddc1_nco_inc,
	output logic      [9:0]  ddc1_nco_phase
);

	typedef struct packed {
		logic [NSLOT-1:0][7:0] m;
		logic [NSLOT-1:0][7:0] s;
		logic [31:0]           rdata;
		logic                  err;
		logic [NCO_W-1:0]      ph0;
		logic [NCO_W-1:0]      ph1;
	} adcr_state_t;

	adcr_state_t r_reg;
	adcr_state_t r_next;

	// Slot lookup: bit 4 flags a shadowed register, bits 3:0 give its slot
	function automatic logic [4:0] slot_of(input logic [9:0] idx);
		case (idx)
			IDX_THR:    slot_of = {1'b1, SL_THR};
			IDX_CALCTL: slot_of = {1'b1, SL_CALCTL};
			IDX_DIVIDED_CLOCK_OUTPUT: slot_of = {1'b1, SL_DIVIDED_CLOCK_OUTPUT};
			IDX_TRIM:   slot_of = {1'b1, SL_TRIM};
			IDX_RSV:    slot_of = {1'b1, SL_RSV};
			IDX_G0:     slot_of = {1'b1, SL_G0};
			IDX_N0L:    slot_of = {1'b1, SL_N0L};
			IDX_N0H:    slot_of = {1'b1, SL_N0H};
			IDX_G1:     slot_of = {1'b1, SL_G1};
			IDX_N1L:    slot_of = {1'b1, SL_N1L};
			IDX_N1H:    slot_of = {1'b1, SL_N1H};
			default:    slot_of = 5'h00;
		endcase
	endfunction : slot_of

	// Implemented bits of each slot, used for both write and read
	function automatic logic [7:0] slot_mask(input logic [3:0] sl);
		case (sl)
			SL_CALCTL: slot_mask = MSK_CALCTL;
			SL_DIVIDED_CLOCK_OUTPUT: slot_mask = MSK_DIVIDED_CLOCK_OUTPUT;
			SL_TRIM:   slot_mask = MSK_LOW2;
			SL_G0:     slot_mask = MSK_GAIN;
			SL_G1:     slot_mask = MSK_GAIN;
			SL_N0H:    slot_mask = MSK_LOW2;
			SL_N1H:    slot_mask = MSK_LOW2;
			default:   slot_mask = MSK_FULL;
		endcase
	endfunction : slot_mask

	function automatic logic [7:0] slot_reset(input logic [3:0] sl);
		case (sl)
			SL_THR:    slot_reset = RST_THR;
			SL_CALCTL: slot_reset = RST_CALCTL;
			SL_DIVIDED_CLOCK_OUTPUT: slot_reset = RST_DIVIDED_CLOCK_OUTPUT;
			SL_TRIM:   slot_reset = (GRADE == ADCR_GRADE_SLOW) ? RST_TRIM_SLOW
			                                                   : RST_TRIM_FAST;
			SL_RSV:    slot_reset = RST_RSV;
			default:   slot_reset = RST_ZERO;
		endcase
	endfunction : slot_reset

	// Request decode
	logic [9:0] idx;
	logic [4:0] slot_info;
	logic [3:0] slot;
	logic       slot_ok;
	logic       addr_ok;
	logic       wr_take;
	logic       div_en;

	assign idx       = paddr[11:2];
	assign slot_info = slot_of(idx);
	assign slot      = slot_info[3:0];
	assign slot_ok   = slot_info[4];
	assign addr_ok   = (paddr[1:0] == 2'b00) && (slot_ok || idx == IDX_XFER);
	// Access phase is one cycle while ce is high; a frozen clock enable stretches it
	assign pready    = psel & penable & ce;
	assign wr_take   = pready & pwrite;

	// Reset image of the whole state
	adcr_state_t r_init;
	genvar gi;
	generate
		for (gi = 0; gi < NSLOT; gi++) begin : g_init
			assign r_init.m[gi] = slot_reset(4'(gi));
			assign r_init.s[gi] = slot_reset(4'(gi));
		end
	endgenerate
	assign r_init.rdata = '0;
	assign r_init.err   = 1'b0;
	assign r_init.ph0   = '0;
	assign r_init.ph1   = '0;

	always_comb begin
		r_next = r_reg;
		if (ce) begin
			// Setup phase: read data and error are registered ahead of the access
			if (psel && !penable) begin
				r_next.err   = !addr_ok;
				r_next.rdata = '0;
				if (!pwrite && slot_ok && paddr[1:0] == 2'b00) begin
					r_next.rdata[7:0] = r_reg.m[slot] & slot_mask(slot);
				end
			end
			if (wr_take && addr_ok) begin
				if (slot_ok) begin
					r_next.m[slot] = pwdata[7:0] & slot_mask(slot);
					// Slow grade has only the lowest-rate trim; other codes are refused
					if (GRADE == ADCR_GRADE_SLOW && slot == SL_TRIM) begin
						r_next.m[SL_TRIM] = RST_TRIM_SLOW;
					end
				end else if (pwdata[BIT_XFER]) begin
					// Self-clearing: nothing is stored, so the bit reads zero
					r_next.s = r_reg.m;
				end
			end
			// Phase accumulators: wrap at 1024 gives inc * fs / 1024
			r_next.ph0 = r_reg.ph0 + ddc0_nco_inc;
			r_next.ph1 = r_reg.ph1 + ddc1_nco_inc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= r_init;
		end else begin
			r_reg <= r_next;
		end
	end

	// Bus answers
	assign prdata  = r_reg.rdata;
	assign pslverr = pready & r_reg.err;

	// Functional outputs come from the slave copies only
	assign div_en                = r_reg.s[SL_DIVIDED_CLOCK_OUTPUT][BIT_DIV_EN];
	assign divided_clock_output_term_none      = r_reg.s[SL_DIVIDED_CLOCK_OUTPUT][BIT_DIV_TERM];
	assign divided_clock_output_swing          = r_reg.s[SL_DIVIDED_CLOCK_OUTPUT][POS_SWING+:2];
	// Code 0 is the top range on the faster grades; the range table differs by grade
	assign trim_code             = r_reg.s[SL_TRIM][1:0];
	assign gain_cal_threshold    = r_reg.s[SL_THR];
	assign gain_cal_threshold_en = r_reg.s[SL_CALCTL][BIT_CAL_EN];
	assign reserved_cfg          = r_reg.s[SL_RSV];
	assign ddc0_gain_d2          = r_reg.s[SL_G0][POS_GAIN_D2+:2];
	assign ddc0_gain_d8          = r_reg.s[SL_G0][POS_GAIN_D8+:2];
	assign ddc1_gain_d2          = r_reg.s[SL_G1][POS_GAIN_D2+:2];
	assign ddc1_gain_d8          = r_reg.s[SL_G1][POS_GAIN_D8+:2];
	assign ddc0_nco_inc          = {r_reg.s[SL_N0H][1:0], r_reg.s[SL_N0L]};
	assign ddc1_nco_inc          = {r_reg.s[SL_N1H][1:0], r_reg.s[SL_N1L]};
	assign ddc0_nco_phase        = r_reg.ph0;
	assign ddc1_nco_phase        = r_reg.ph1;

	adcr_clkdiv #(
		.RATIO   (DIV_RATIO)
	) u_clkdiv (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.en      (div_en),
		.clk_out (divided_clock_output)
	);

	// Checks
	property p_master_only;
		@(posedge pclk) disable iff (!presetn)
		(wr_take && idx != IDX_XFER) |=> $stable(r_reg.s);
	endproperty
	a_master_only: assert property (p_master_only)
		else $error("slave registers changed without a transfer");

	property p_transfer;
		@(posedge pclk) disable iff (!presetn)
		(wr_take && idx == IDX_XFER && paddr[1:0] == 2'b00 && pwdata[BIT_XFER])
			|=> (r_reg.s == $past(r_reg.m));
	endproperty
	a_transfer: assert property (p_transfer)
		else $error("transfer did not copy master registers");

	property p_div_off;
		@(posedge pclk) disable iff (!presetn)
		(!div_en && ce) |=> !divided_clock_output;
	endproperty
	a_div_off: assert property (p_div_off)
		else $error("divided clock active while disabled");

	property p_div_quarter;
		@(posedge pclk) disable iff (!presetn)
		(div_en && ce) [*4] |-> (divided_clock_output != $past(divided_clock_output, 2));
	endproperty
	a_div_quarter: assert property (p_div_quarter)
		else $error("divided clock not at quarter rate");

	property p_read_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && slot_ok) |->
			(prdata[31:8] == 24'h0) && ((prdata[7:0] & ~slot_mask(slot)) == 8'h00);
	endproperty
	a_read_zero: assert property (p_read_zero)
		else $error("unused bits read nonzero");

	property p_slow_trim;
		@(posedge pclk) disable iff (!presetn)
		(GRADE == ADCR_GRADE_SLOW) |-> (trim_code == 2'b11);
	endproperty
	a_slow_trim: assert property (p_slow_trim)
		else $error("slow grade trim code not 3");

	property p_nco_step;
		@(posedge pclk) disable iff (!presetn)
		ce |=> (ddc0_nco_phase == 10'($past(ddc0_nco_phase) + $past(ddc0_nco_inc)));
	endproperty
	a_nco_step: assert property (p_nco_step)
		else $error("channel 0 phase step wrong");

	property p_reset_values;
		@(posedge pclk) disable iff (!presetn)
		$rose(presetn) |-> (gain_cal_threshold == RST_THR) &&
			(r_reg.m[SL_TRIM] == slot_reset(SL_TRIM));
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("register reset value wrong");

	property p_bad_write;
		@(posedge pclk) disable iff (!presetn)
		(wr_take && !addr_ok) |-> pslverr ##1 $stable(r_reg.m);
	endproperty
	a_bad_write: assert property (p_bad_write)
		else $error("unmapped write not refused");

	property p_write_master;
		@(posedge pclk) disable iff (!presetn)
		(wr_take && addr_ok && slot_ok && !(GRADE == ADCR_GRADE_SLOW && slot == SL_TRIM))
			|=> (r_reg.m[$past(slot)] == ($past(pwdata[7:0]) & slot_mask($past(slot))));
	endproperty
	a_write_master: assert property (p_write_master)
		else $error("write did not land in master register");

	property p_xfer_keeps_master;
		@(posedge pclk) disable iff (!presetn)
		(wr_take && idx == IDX_XFER) |=> $stable(r_reg.m);
	endproperty
	a_xfer_keeps_master: assert property (p_xfer_keeps_master)
		else $error("transfer write altered master registers");

	property p_xfer_reads_zero;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && idx == IDX_XFER) |-> (prdata == 32'h0);
	endproperty
	a_xfer_reads_zero: assert property (p_xfer_reads_zero)
		else $error("transfer bit read back nonzero");

	property p_refused_read;
		@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && !addr_ok) |-> pslverr && (prdata == 32'h0);
	endproperty
	a_refused_read: assert property (p_refused_read)
		else $error("unmapped read not refused");

	// Read data moves only at a setup edge, so it stands through any wait
	property p_rdata_hold;
		@(posedge pclk) disable iff (!presetn)
		!(psel && !penable) |=> $stable(prdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data moved outside setup");

	property p_freeze;
		@(posedge pclk) disable iff (!presetn)
		!ce |=> $stable(r_reg) && $stable(divided_clock_output);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved while clock enable low");

	property p_nco1_step;
		@(posedge pclk) disable iff (!presetn)
		ce |=> (ddc1_nco_phase == 10'($past(ddc1_nco_phase) + $past(ddc1_nco_inc)));
	endproperty
	a_nco1_step: assert property (p_nco1_step)
		else $error("channel 1 phase step wrong");

	property p_div_restart;
		@(posedge pclk) disable iff (!presetn)
		((!div_en && ce) ##1 (div_en && ce) [*3])
			|-> !divided_clock_output ##1 divided_clock_output;
	endproperty
	a_div_restart: assert property (p_div_restart)
		else $error("divided clock did not restart low then high");

endmodule : adcr_regs

//--- test/adcr_regs_tb.sv
/*
 * Self-checking bench for the converter configuration register slice.
 * Assumes the standard speed grade and a 10 MHz pclk; a slow-grade copy on the
 * same bus has only its trim watched. The bench acts as the APB master and
 * keeps a master/slave model of every register.
 */
module adcr_regs_tb import adcr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        divided_clock_output;
	logic        divided_clock_output_term_none;
	logic [1:0]  divided_clock_output_swing;
	logic [1:0]  trim_code;
	logic [7:0]  gain_cal_threshold;
	logic        gain_cal_threshold_en;
	logic [7:0]  reserved_cfg;
	logic [1:0]  ddc0_gain_d2;
	logic [1:0]  ddc0_gain_d8;
	logic [9:0]  ddc0_nco_inc;
	logic [9:0]  ddc0_nco_phase;
	logic [1:0]  ddc1_gain_d2;
	logic [1:0]  ddc1_gain_d8;
	logic [9:0]  ddc1_nco_inc;
	logic [9:0]  ddc1_nco_phase;
	logic [1:0]  trim_slow;
	int          failures;
	int          samples_checked;
	logic [31:0] rd_v;
	logic        err_v;
	logic [7:0]  m [NSLOT];
	logic [7:0]  s [NSLOT];

	// Table order matches the slot numbering of the package
	localparam logic [9:0] IDXS [NSLOT] = '{IDX_THR, IDX_CALCTL, IDX_DIVIDED_CLOCK_OUTPUT, IDX_TRIM, IDX_RSV,
		IDX_G0, IDX_N0L, IDX_N0H, IDX_G1, IDX_N1L, IDX_N1H};
	localparam logic [7:0] MSKS [NSLOT] = '{MSK_FULL, MSK_CALCTL, MSK_DIVIDED_CLOCK_OUTPUT, MSK_LOW2, MSK_FULL,
		MSK_GAIN, MSK_FULL, MSK_LOW2, MSK_GAIN, MSK_FULL, MSK_LOW2};
	localparam logic [7:0] RSTS [NSLOT] = '{RST_THR, RST_CALCTL, RST_DIVIDED_CLOCK_OUTPUT, RST_TRIM_FAST, RST_RSV,
		RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};

	adcr_regs #(.GRADE(ADCR_GRADE_STD)) u_adcr_regs (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .divided_clock_output(divided_clock_output),
		.divided_clock_output_term_none(divided_clock_output_term_none), .divided_clock_output_swing(divided_clock_output_swing),
		.trim_code(trim_code), .gain_cal_threshold(gain_cal_threshold),
		.gain_cal_threshold_en(gain_cal_threshold_en), .reserved_cfg(reserved_cfg),
		.ddc0_gain_d2(ddc0_gain_d2), .ddc0_gain_d8(ddc0_gain_d8), .ddc0_nco_inc(ddc0_nco_inc),
		.ddc0_nco_phase(ddc0_nco_phase), .ddc1_gain_d2(ddc1_gain_d2),
		.ddc1_gain_d8(ddc1_gain_d8), .ddc1_nco_inc(ddc1_nco_inc),
		.ddc1_nco_phase(ddc1_nco_phase));

	// Slow grade copy on the same bus; only its trim output is watched
	adcr_regs #(.GRADE(ADCR_GRADE_SLOW)) u_adcr_regs_slow (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
		.divided_clock_output(), .divided_clock_output_term_none(), .divided_clock_output_swing(), .trim_code(trim_slow),
		.gain_cal_threshold(), .gain_cal_threshold_en(), .reserved_cfg(), .ddc0_gain_d2(),
		.ddc0_gain_d8(), .ddc0_nco_inc(), .ddc0_nco_phase(), .ddc1_gain_d2(),
		.ddc1_gain_d8(), .ddc1_nco_inc(), .ddc1_nco_phase());

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	function automatic logic [49:0] exp_out();
		return {s[SL_DIVIDED_CLOCK_OUTPUT][BIT_DIV_TERM], s[SL_DIVIDED_CLOCK_OUTPUT][1:0], s[SL_TRIM][1:0], s[SL_THR],
			s[SL_CALCTL][BIT_CAL_EN], s[SL_RSV], s[SL_G0][5:4], s[SL_G0][1:0],
			s[SL_N0H][1:0], s[SL_N0L], s[SL_G1][5:4], s[SL_G1][1:0], s[SL_N1H][1:0], s[SL_N1L]};
	endfunction : exp_out

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd,
		input logic stall, output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= {24'($urandom), wd};
		@(posedge pclk);
		penable <= 1'b1;
		if (stall) begin
			ce <= 1'b0;
			repeat (3) begin
				@(posedge pclk);
				cmp({63'h0, pready}, 64'h0);
			end
			ce <= 1'b1;
		end
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			failures++;
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, {idx, 2'b00}, d, 1'b0, rd_v, err_v);
		cmp({63'h0, err_v}, 64'h0);
	endtask : wr

	task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
		apb(1'b0, {idx, 2'b00}, 8'h00, 1'b0, rd_v, err_v);
		cmp({31'h0, err_v, rd_v}, {32'h0, 24'h0, e});
	endtask : rdc

	// Slave copies only move on the transfer strobe; the stall variant holds ce low
	task automatic xfer(input logic stall);
		apb(1'b1, {IDX_XFER, 2'b00}, 8'h01, stall, rd_v, err_v);
		s = m;
		cmp({63'h0, err_v}, 64'h0);
	endtask : xfer

	task automatic chk_out();
		repeat (2) @(negedge pclk);
		cmp({14'h0, divided_clock_output_term_none, divided_clock_output_swing, trim_code, gain_cal_threshold,
			gain_cal_threshold_en, reserved_cfg, ddc0_gain_d2, ddc0_gain_d8, ddc0_nco_inc,
			ddc1_gain_d2, ddc1_gain_d8, ddc1_nco_inc}, {14'h0, exp_out()});
		cmp({62'h0, trim_slow}, 64'h3);
	endtask : chk_out

	// Phase of the divided clock is free, so any rotation of 0011 is accepted
	task automatic chk_div(input logic en);
		logic [7:0] v;
		repeat (3) @(negedge pclk);
		for (int i = 0; i < 8; i++) begin
			v[i] = divided_clock_output;
			@(negedge pclk);
		end
		if (en)
			cmp({63'h0, v[3:0] === v[7:4] && v[3:0] inside {4'h3, 4'h6, 4'hc, 4'h9}}, 64'h1);
		else
			cmp({56'h0, v}, 64'h0);
	endtask : chk_div

	task automatic chk_nco();
		logic [9:0] p0;
		logic [9:0] q0;
		@(negedge pclk);
		p0 = ddc0_nco_phase;
		q0 = ddc1_nco_phase;
		@(negedge pclk);
		cmp({44'h0, ddc0_nco_phase, ddc1_nco_phase},
			{44'h0, 10'(p0 + {s[SL_N0H][1:0], s[SL_N0L]}), 10'(q0 + {s[SL_N1H][1:0], s[SL_N1L]})});
	endtask : chk_nco

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		wrap_up();
	end

	initial begin
		logic [7:0] d;
		failures = 0;
		samples_checked = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		void'($urandom(32'h1e2d124d));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < NSLOT; i++) begin
			m[i] = RSTS[i];
			s[i] = RSTS[i];
			rdc(IDXS[i], RSTS[i]);
		end
		chk_out();
		$display("test reset values done");
		chk_div(1'b1);
		m[SL_DIVIDED_CLOCK_OUTPUT] = 8'h01;
		wr(IDX_DIVIDED_CLOCK_OUTPUT, 8'h01);
		xfer(1'b0);
		chk_div(1'b0);
		$display("test divided clock done");
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < NSLOT; i++) begin
				d = 8'($urandom);
				d[1:0] = 2'(k);
				d[5:4] = ~2'(k);
				if (i == SL_RSV)
					d = RST_RSV;
				wr(IDXS[i], d);
				m[i] = d & MSKS[i];
			end
			chk_out();
			for (int i = 0; i < NSLOT; i++)
				rdc(IDXS[i], m[i]);
			xfer(k == 3);
			chk_out();
			chk_nco();
			if (k[0])
				chk_div(m[SL_DIVIDED_CLOCK_OUTPUT][BIT_DIV_EN]);
		end
		$display("test random shadowed registers done");
		apb(1'b0, 12'h400, 8'h00, 1'b0, rd_v, err_v);
		cmp({31'h0, err_v, rd_v}, {31'h0, 1'b1, 32'h0});
		apb(1'b1, {IDX_THR, 2'b01}, 8'hff, 1'b0, rd_v, err_v);
		cmp({63'h0, err_v}, 64'h1);
		rdc(IDX_THR, m[SL_THR]);
		rdc(IDX_XFER, 8'h00);
		$display("test refused accesses done");
		wrap_up();
	end

endmodule : adcr_regs_tb
